// >>> logic/thic_ctl.sv
// host-side command and status port of a streaming tape formatter.
// assumes host pins are asynchronous to core_clk; transport-side signals
// (sensors, character handshakes, error events) are on core_clk.
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps

module thic_ctl #(
   parameter int RAMP_CYCLES = thic_pkg::RAMP_CYC,
   parameter int CW = thic_pkg::CHAR_W
) (
   input wire logic core_clk,
   input wire logic rst,
   // axi4-lite slave
   input wire logic [thic_pkg::ADDR_W-1:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [thic_pkg::ADDR_W-1:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // host pins
   input wire logic formatter_addr_in,
   input wire logic [1:0] transport_addr_in,
   input wire logic initiate_cmd_in,
   input wire logic formatter_enable_in,
   input wire logic reverse_in,
   input wire logic rewind_in,
   input wire logic rewind_unload_in,
   input wire logic write_mode_in,
   input wire logic edit_in,
   input wire logic write_filemark_in,
   input wire logic last_char_in,
   input wire logic [CW-1:0] write_data_in,
   output logic ready_out,
   output logic online_out,
   output logic formatter_busy_out,
   output logic data_busy_out,
   output logic hard_error_out,
   output logic soft_error_out,
   output logic write_protect_out,
   output logic load_point_out,
   output logic end_of_tape_out,
   output logic rewinding_out,
   output logic ident_out,
   output logic write_strobe_out,
   output logic read_strobe_out,
   output logic [CW-1:0] read_data_out,
   // transport side, core_clk domain
   input wire logic bot_sensor,
   input wire logic eot_sensor,
   input wire logic ring_present,
   input wire logic cmd_done,
   input wire logic wr_char_taken,
   input wire logic rd_char_valid,
   input wire logic [CW-1:0] rd_char,
   input wire logic hard_err_evt,
   input wire logic soft_err_evt,
   output logic motion_run,
   output logic motion_reverse,
   output logic unload_req,
   output logic mode_write,
   output logic mode_edit,
   output logic mode_filemark,
   output logic [CW-1:0] wr_char,
   output logic wr_char_last
);

   // ==========================================================
   // pin synchronisers
   localparam int PW = $bits(thic_pkg::thic_pins_t);
   thic_pkg::thic_pins_t pins_raw;
   logic [PW-1:0] sync_a;
   logic [PW-1:0] sync_b;
   thic_pkg::thic_pins_t pins;
   logic init_prev;

   assign pins_raw.formatter_addr = formatter_addr_in;
   assign pins_raw.transport_addr = transport_addr_in;
   assign pins_raw.initiate = initiate_cmd_in;
   assign pins_raw.enable = formatter_enable_in;
   assign pins_raw.last_char = last_char_in;
   assign pins_raw.cmd.reverse = reverse_in;
   assign pins_raw.cmd.rewind = rewind_in;
   assign pins_raw.cmd.rewind_unload = rewind_unload_in;
   assign pins_raw.cmd.write_mode = write_mode_in;
   assign pins_raw.cmd.edit = edit_in;
   assign pins_raw.cmd.write_filemark = write_filemark_in;
   assign pins_raw.write_data = write_data_in;

   // the first stage feeds only the second; nothing else looks at it
   for (genvar i = 0; i < PW; i++) begin : g_sync
      always_ff @(posedge core_clk or posedge rst) begin
         if (rst) begin
            sync_a[i] <= 1'b0;
            sync_b[i] <= 1'b0;
         end else begin
            sync_a[i] <= pins_raw[i];
            sync_b[i] <= sync_a[i];
         end
      end
   end
   assign pins = thic_pkg::thic_pins_t'(sync_b);

   // ==========================================================
   // state and decode
   logic [thic_pkg::UNIT_W-1:0] unit_num;
   logic online_state;
   logic online_set_req;
   logic online_clr_req;
   logic rewinding;
   logic unload_pending;
   logic hard_err;
   logic soft_err;
   logic bot_prev;
   thic_pkg::thic_state_t state;
   thic_pkg::thic_cmd_t cmd_q;
   logic [$clog2(RAMP_CYCLES+1)-1:0] ramp_cnt;
   logic unit_selected;
   logic iface_enabled;
   logic ready_int;
   logic init_edge;
   logic go;
   logic go_motion;
   logic go_rewind;
   logic go_unload;

   assign unit_selected = (unit_num == {pins.formatter_addr, pins.transport_addr});
   assign iface_enabled = !rewinding && unit_selected && online_state;
   assign ready_int = online_state && !rewinding && (state == thic_pkg::ST_IDLE);
   // unselected units never see the initiate edge
   assign init_edge = pins.initiate && !init_prev && unit_selected && pins.enable;
   assign go = init_edge && iface_enabled && (state == thic_pkg::ST_IDLE);
   assign go_unload = go && pins.cmd.rewind_unload;
   assign go_rewind = go && !pins.cmd.rewind_unload && pins.cmd.rewind && ready_int
                      && !bot_sensor;
   assign go_motion = go && !pins.cmd.rewind_unload && !pins.cmd.rewind;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         init_prev <= 1'b0;
         bot_prev <= 1'b0;
      end else begin
         init_prev <= pins.initiate;
         bot_prev <= bot_sensor;
      end
   end

   // command latch
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cmd_q <= '0;
      end else if (go) begin
         cmd_q <= pins.cmd;
      end
   end

   // on-line flag: set strobe wins over any clear in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         online_state <= 1'b0;
      end else if (online_set_req) begin
         online_state <= 1'b1;
      end else if (online_clr_req || go_unload) begin
         online_state <= 1'b0;
      end
   end

   // rewind flag: ends when the bot marker arrives
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rewinding <= 1'b0;
         unload_pending <= 1'b0;
         unload_req <= 1'b0;
      end else begin
         unload_req <= 1'b0;
         if (go_rewind || go_unload) begin
            rewinding <= 1'b1;
            unload_pending <= go_unload;
         end else if (rewinding && bot_sensor) begin
            rewinding <= 1'b0;
            unload_pending <= 1'b0;
            unload_req <= unload_pending;
         end
      end
   end

   // motion sequencer
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= thic_pkg::ST_IDLE;
         ramp_cnt <= '0;
      end else begin
         case (state)
            thic_pkg::ST_IDLE: begin
               ramp_cnt <= '0;
               if (go_motion) begin
                  state <= thic_pkg::ST_RAMP;
               end else if (go_rewind || go_unload) begin
                  state <= thic_pkg::ST_REWIND;
               end
            end
            thic_pkg::ST_RAMP: begin
               // simulated ramp before data busy rises
               if (32'(ramp_cnt) >= RAMP_CYCLES - 1) begin
                  state <= thic_pkg::ST_RUN;
               end else begin
                  ramp_cnt <= ramp_cnt + 1'b1;
               end
            end
            thic_pkg::ST_RUN: begin
               if (cmd_done) begin
                  state <= thic_pkg::ST_IDLE;
               end
            end
            thic_pkg::ST_REWIND: begin
               if (bot_sensor) begin
                  state <= thic_pkg::ST_IDLE;
               end
            end
            default: state <= thic_pkg::ST_IDLE;
         endcase
      end
   end

   // transport controls
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         motion_run <= 1'b0;
         motion_reverse <= 1'b0;
         mode_write <= 1'b0;
         mode_edit <= 1'b0;
         mode_filemark <= 1'b0;
      end else begin
         motion_run <= (state != thic_pkg::ST_IDLE);
         motion_reverse <= (state == thic_pkg::ST_REWIND) || cmd_q.reverse;
         mode_write <= cmd_q.write_mode;
         mode_edit <= cmd_q.edit && cmd_q.write_mode;
         mode_filemark <= cmd_q.write_filemark && cmd_q.write_mode;
      end
   end

   // error flags: a hard error event in the clearing cycle still lands
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hard_err <= 1'b0;
         soft_err <= 1'b0;
      end else begin
         hard_err <= hard_err_evt || (hard_err && !go);
         soft_err <= (soft_err_evt && (state == thic_pkg::ST_RUN)) || (soft_err && !go);
      end
   end

   // character path; strobes are registered copies of wr_char_taken and rd_char_valid, gated by ST_RUN, write_mode direction and unit select
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         write_strobe_out <= 1'b0;
         read_strobe_out <= 1'b0;
         read_data_out <= '0;
         wr_char <= '0;
         wr_char_last <= 1'b0;
      end else begin
         wr_char <= pins.write_data;
         wr_char_last <= pins.last_char && cmd_q.write_mode;
         write_strobe_out <= wr_char_taken && (state == thic_pkg::ST_RUN)
                             && cmd_q.write_mode && unit_selected;
         read_strobe_out <= rd_char_valid && (state == thic_pkg::ST_RUN)
                            && !cmd_q.write_mode && unit_selected;
         if (rd_char_valid && !cmd_q.write_mode) begin
            read_data_out <= rd_char;
         end
      end
   end

   // status toward the host, all forced inactive when not selected
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ready_out <= 1'b0;
         online_out <= 1'b0;
         formatter_busy_out <= 1'b0;
         data_busy_out <= 1'b0;
         hard_error_out <= 1'b0;
         soft_error_out <= 1'b0;
         write_protect_out <= 1'b0;
         load_point_out <= 1'b0;
         end_of_tape_out <= 1'b0;
         rewinding_out <= 1'b0;
         ident_out <= 1'b0;
      end else begin
         ready_out <= unit_selected && ready_int;
         online_out <= unit_selected && online_state;
         formatter_busy_out <= unit_selected && (state != thic_pkg::ST_IDLE);
         data_busy_out <= unit_selected && (state == thic_pkg::ST_RUN);
         hard_error_out <= unit_selected && hard_err;
         soft_error_out <= unit_selected && soft_err;
         write_protect_out <= unit_selected && !ring_present;
         load_point_out <= unit_selected && bot_sensor;
         end_of_tape_out <= unit_selected && eot_sensor;
         rewinding_out <= unit_selected && rewinding;
         // head leaves the marker moving forward while reading
         ident_out <= unit_selected && bot_prev && !bot_sensor
                      && (state == thic_pkg::ST_RUN) && !cmd_q.reverse
                      && !cmd_q.write_mode;
      end
   end

   // ==========================================================
   // axi4-lite write channel
   logic aw_held;
   logic w_held;
   logic [thic_pkg::ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_awready <= 1'b0;
         s_wready <= 1'b0;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         s_bvalid <= 1'b0;
         s_bresp <= thic_pkg::RESP_OKAY;
         unit_num <= thic_pkg::UNIT_RST;
         online_set_req <= 1'b0;
         online_clr_req <= 1'b0;
      end else begin
         online_set_req <= 1'b0;
         online_clr_req <= 1'b0;
         if (s_awvalid && s_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_awaddr;
            s_awready <= 1'b0;
         end else if (!aw_held && !s_bvalid) begin
            s_awready <= 1'b1;
         end
         if (s_wvalid && s_wready) begin
            w_held <= 1'b1;
            w_data_q <= s_wdata;
            w_strb_q <= s_wstrb;
            s_wready <= 1'b0;
         end else if (!w_held && !s_bvalid) begin
            s_wready <= 1'b1;
         end
         if (aw_held && w_held && !s_bvalid) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= thic_pkg::RESP_OKAY;
            case (aw_addr_q)
               thic_pkg::REG_CTRL: begin
                  if (w_strb_q[0]) begin
                     unit_num <= w_data_q[thic_pkg::CTRL_UNIT_LSB +: thic_pkg::UNIT_W];
                     online_set_req <= w_data_q[thic_pkg::CTRL_ONL_SET_BIT];
                     online_clr_req <= w_data_q[thic_pkg::CTRL_ONL_CLR_BIT];
                  end
               end
               thic_pkg::REG_STATUS, thic_pkg::REG_CMD, thic_pkg::REG_DATA: begin
                  s_bresp <= thic_pkg::RESP_OKAY;
               end
               default: s_bresp <= thic_pkg::RESP_SLVERR;
            endcase
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // axi4-lite read channel
   logic [31:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[thic_pkg::ST_ONLINE_BIT] = online_state;
      status_word[thic_pkg::ST_REWIND_BIT] = rewinding;
      status_word[thic_pkg::ST_SELECT_BIT] = unit_selected;
      status_word[thic_pkg::ST_READY_BIT] = ready_int;
      status_word[thic_pkg::ST_FBUSY_BIT] = (state != thic_pkg::ST_IDLE);
      status_word[thic_pkg::ST_DBUSY_BIT] = (state == thic_pkg::ST_RUN);
      status_word[thic_pkg::ST_HERR_BIT] = hard_err;
      status_word[thic_pkg::ST_SERR_BIT] = soft_err;
      status_word[thic_pkg::ST_STATE_LSB +: 2] = state;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s_arready <= 1'b0;
         s_rvalid <= 1'b0;
         s_rdata <= '0;
         s_rresp <= thic_pkg::RESP_OKAY;
      end else begin
         if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rresp <= thic_pkg::RESP_OKAY;
            case (s_araddr)
               thic_pkg::REG_CTRL: s_rdata <= 32'(unit_num);
               thic_pkg::REG_STATUS: s_rdata <= status_word;
               thic_pkg::REG_CMD: s_rdata <= 32'(cmd_q);
               thic_pkg::REG_DATA: s_rdata <= 32'(read_data_out);
               default: begin
                  s_rdata <= '0;
                  s_rresp <= thic_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end else if (!s_rvalid) begin
            s_arready <= 1'b1;
         end
      end
   end

endmodule // thic_ctl

// >>> logic/thic_pkg.sv
// package for the tape host interface control block: register map, fields,
// reset values, timing counts, command and pin carriers, sequencer states.
// assumes a 50 MHz core clock and a 32-bit axi4-lite register bus.
package thic_pkg;

   // ==========================================================
   // register map
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CMD = 8'h08;
   localparam logic [7:0] REG_DATA = 8'h0C;

   // ==========================================================
   // field positions and reset values
   localparam int CTRL_UNIT_LSB = 0;
   localparam int UNIT_W = 3;
   localparam int CTRL_ONL_SET_BIT = 4;
   localparam int CTRL_ONL_CLR_BIT = 5;
   localparam logic [2:0] UNIT_RST = 3'h0;
   localparam int ST_ONLINE_BIT = 0;
   localparam int ST_REWIND_BIT = 1;
   localparam int ST_SELECT_BIT = 2;
   localparam int ST_READY_BIT = 3;
   localparam int ST_FBUSY_BIT = 4;
   localparam int ST_DBUSY_BIT = 5;
   localparam int ST_HERR_BIT = 6;
   localparam int ST_SERR_BIT = 7;
   localparam int ST_STATE_LSB = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int RAMP_NS = 10000;
   localparam int RAMP_CYC = (RAMP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CHAR_W = 9;

   // ==========================================================
   // carriers
   typedef struct packed {
      logic reverse;
      logic rewind;
      logic rewind_unload;
      logic write_mode;
      logic edit;
      logic write_filemark;
   } thic_cmd_t;

   typedef struct packed {
      logic formatter_addr;
      logic [1:0] transport_addr;
      logic initiate;
      logic enable;
      logic last_char;
      thic_cmd_t cmd;
      logic [CHAR_W-1:0] write_data;
   } thic_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RAMP,
      ST_RUN,
      ST_REWIND
   } thic_state_t;

endpackage

// >>> tb/thic_ctl_assertions.sv
// checker for the tape host port: output relations at the top ports.
// assumes core_clk domain only and rst async active high.
`timescale 1ns/10ps
module thic_ctl_assertions #(
   parameter int CW = 9
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic ready_out,
   input wire logic online_out,
   input wire logic rewinding_out,
   input wire logic formatter_busy_out,
   input wire logic data_busy_out,
   input wire logic motion_run,
   input wire logic motion_reverse,
   input wire logic mode_write,
   input wire logic mode_edit,
   input wire logic mode_filemark,
   input wire logic write_protect_out,
   input wire logic ring_present,
   input wire logic load_point_out,
   input wire logic bot_sensor,
   input wire logic write_strobe_out,
   input wire logic wr_char_taken,
   input wire logic read_strobe_out,
   input wire logic rd_char_valid,
   input wire logic [CW-1:0] read_data_out,
   input wire logic [CW-1:0] rd_char,
   input wire logic unload_req
);
   // ==========================================
   // properties
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   ready_idle_a: assert property (ready_out |-> online_out && !rewinding_out
      && !formatter_busy_out) else $error("ready while busy or offline");
   dbusy_ramp_a: assert property ($rose(formatter_busy_out) |-> !data_busy_out[*3])
      else $error("data busy before ramp");
   dbusy_in_a: assert property (data_busy_out |-> formatter_busy_out)
      else $error("data busy outside command");
   fbusy_run_a: assert property (formatter_busy_out |-> motion_run)
      else $error("busy without motion");
   rewind_rev_a: assert property (rewinding_out |-> motion_reverse && !ready_out)
      else $error("rewind not reverse");
   mode_write_a: assert property (mode_edit || mode_filemark |-> mode_write)
      else $error("edit or mark without write");
   protect_ring_a: assert property (write_protect_out |-> !$past(ring_present))
      else $error("protect with ring");
   load_point_a: assert property (load_point_out |-> $past(bot_sensor))
      else $error("load point off marker");
   wstrobe_a: assert property (write_strobe_out |-> $past(wr_char_taken))
      else $error("write strobe without record");
   rstrobe_a: assert property (read_strobe_out |-> $past(rd_char_valid)
      && read_data_out == $past(rd_char)) else $error("read strobe data wrong");
   unload_off_a: assert property (unload_req |-> !online_out)
      else $error("unload while online");
endmodule // thic_ctl_assertions

bind thic_ctl thic_ctl_assertions #(.CW(CW)) chk_i (.*);

// >>> tb/thic_host_model.sv
// host controller model: drives address, command and write data pins.
// assumes its tasks are entered just after a rising core_clk edge.
`timescale 1ns/10ps
module thic_host_model (
   input wire logic core_clk,
   output thic_pkg::thic_pins_t pins
);
   // ==========================================
   // pin drive
   initial pins = '0;
   // lines settle before initiate and stay put after it
   task automatic issue(input thic_pkg::thic_cmd_t c);
      pins.cmd <= c;
      pins.enable <= 1'b1;
      repeat (2) @(posedge core_clk);
      pins.initiate <= 1'b1;
      repeat (3) @(posedge core_clk);
      pins.initiate <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic sel(input logic [2:0] u);
      {pins.formatter_addr, pins.transport_addr} <= u;
      @(posedge core_clk);
   endtask
   // last flag rides with the final character
   task automatic put(input logic [8:0] d, input logic l);
      pins.write_data <= d;
      pins.last_char <= l;
      @(posedge core_clk);
   endtask
endmodule // thic_host_model

// >>> tb/thic_ctl_test.sv
// self-checking bench for the tape host port.
// assumes ramp shortened to 4 cycles; transport side played here.
`timescale 1ns/10ps
module thic_ctl_test;
   localparam logic [1:0] OK = thic_pkg::RESP_OKAY;
   localparam logic [1:0] SLV = thic_pkg::RESP_SLVERR;
   logic core_clk, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [7:0] s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, d;
   logic [3:0] s_wstrb;
   logic [1:0] s_bresp, s_rresp;
   logic ready_out, online_out, formatter_busy_out, data_busy_out, hard_error_out, soft_error_out;
   logic write_protect_out, load_point_out, end_of_tape_out, rewinding_out, ident_out;
   logic write_strobe_out, read_strobe_out, motion_run, motion_reverse, unload_req;
   logic mode_write, mode_edit, mode_filemark, wr_char_last;
   logic bot_sensor, eot_sensor, ring_present, cmd_done, wr_char_taken, rd_char_valid;
   logic hard_err_evt, soft_err_evt;
   logic [8:0] read_data_out, rd_char, wr_char;
   logic [16:0] lf = 17'h17AD1;
   logic [5:0] tbl [5] = '{6'h00, 6'h20, 6'h04, 6'h06, 6'h05};
   thic_pkg::thic_pins_t pins;
   thic_pkg::thic_cmd_t c;
   int error_cnt = 0, checks_done = 0, n_id = 0, n_ul = 0, n_ws = 0, i;
   logic [8:0] exp_q [$];

   thic_host_model hm (.core_clk(core_clk), .pins(pins));
   thic_ctl #(.RAMP_CYCLES(4)) uut (.*, .formatter_addr_in(pins.formatter_addr),
      .transport_addr_in(pins.transport_addr), .initiate_cmd_in(pins.initiate),
      .formatter_enable_in(pins.enable), .reverse_in(pins.cmd.reverse),
      .rewind_in(pins.cmd.rewind), .rewind_unload_in(pins.cmd.rewind_unload),
      .write_mode_in(pins.cmd.write_mode), .edit_in(pins.cmd.edit),
      .write_filemark_in(pins.cmd.write_filemark), .last_char_in(pins.last_char),
      .write_data_in(pins.write_data));

   // ==========================================
   // helpers
   function automatic logic [16:0] nx(input logic [16:0] s);
      return {s[15:0], s[16] ^ s[13]};
   endfunction
   task automatic close_out;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tmo;
      error_cnt++;
      close_out;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %0h want %0h", $time, g, e);
      end
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return formatter_busy_out;
         1: return data_busy_out;
         2: return rewinding_out;
         default: return online_out;
      endcase
   endfunction
   // waits are bounded so a stuck sequencer ends the run
   task automatic wt(input int s, input logic v);
      int n;
      for (n = 0; n < 300 && pick(s) !== v; n++) @(posedge core_clk);
      if (n == 300) tmo;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      int n;
      bit b;
      s_awaddr <= a;
      s_wdata <= v;
      {s_awvalid, s_wvalid, s_bready} <= 3'h7;
      for (n = 0; n < 50 && !b; n++) begin
         @(posedge core_clk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
         if (s_bvalid) begin
            b = 1'b1;
            s_bready <= 1'b0;
            chk(s_bresp, er);
         end
      end
      if (!b) tmo;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
      int n;
      bit b;
      s_araddr <= a;
      {s_arvalid, s_rready} <= 2'h3;
      for (n = 0; n < 50 && !b; n++) begin
         @(posedge core_clk);
         if (s_arready) s_arvalid <= 1'b0;
         if (s_rvalid) begin
            b = 1'b1;
            s_rready <= 1'b0;
            v = s_rdata;
            chk(s_rresp, er);
         end
      end
      if (!b) tmo;
   endtask

   // ==========================================
   // pulse monitors and read model
   always @(posedge core_clk) begin
      if (ident_out === 1'b1) n_id++;
      if (unload_req === 1'b1) n_ul++;
      if (write_strobe_out === 1'b1) n_ws++;
      if (read_strobe_out === 1'b1 && exp_q.size() > 0) chk(read_data_out, exp_q.pop_front());
   end

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ==========================================
   // main sequence
   initial begin
      rst = 1'b1;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, s_awaddr, s_araddr, s_wdata} = '0;
      s_wstrb = 4'hF;
      {cmd_done, wr_char_taken, rd_char_valid, hard_err_evt, soft_err_evt} = '0;
      {eot_sensor, bot_sensor, ring_present, rd_char} = {3'h7, 9'h000};
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk({ready_out, online_out, formatter_busy_out, rewinding_out}, 4'h0);
      rd(thic_pkg::REG_CTRL, d, OK);
      chk(d, 32'h0);
      wr(8'h40, 32'h15, SLV);
      rd(8'h40, d, SLV);
      chk(d, 32'h0);
      hm.sel(3'h5);
      wr(thic_pkg::REG_CTRL, 32'h15, OK);
      repeat (4) @(posedge core_clk);
      chk(online_out, 1'b1);
      chk(ready_out, 1'b1);
      chk({load_point_out, end_of_tape_out}, 2'h3);
      rd(thic_pkg::REG_STATUS, d, OK);
      chk(d[3:0], 4'hD);
      ring_present <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk(write_protect_out, 1'b1);
      ring_present <= 1'b1;
      for (i = 0; i < 5; i++) begin
         c = thic_pkg::thic_cmd_t'(tbl[i]);
         hm.issue(c);
         wt(0, 1'b1);
         chk(motion_reverse, c.reverse);
         chk({mode_write, mode_edit, mode_filemark}, c[2:0]);
         chk(ready_out, 1'b0);
         rd(thic_pkg::REG_CMD, d, OK);
         chk(d, {26'h0, c});
         wt(1, 1'b1);
         bot_sensor <= 1'b0;
         @(posedge core_clk);
         if (c.write_mode) begin
            hm.put(lf[8:0], 1'b1);
            repeat (4) @(posedge core_clk);
            chk({wr_char_last, wr_char}, {1'b1, lf[8:0]});
            wr_char_taken <= 1'b1;
         end else begin
            rd_char <= lf[8:0];
            exp_q.push_back(lf[8:0]);
            rd_char_valid <= 1'b1;
         end
         @(posedge core_clk);
         {wr_char_taken, rd_char_valid, soft_err_evt} <= {2'h0, i == 1};
         lf = nx(lf);
         repeat (3) @(posedge core_clk);
         if (i == 1) chk(soft_error_out, 1'b1);
         cmd_done <= 1'b1;
         @(posedge core_clk);
         cmd_done <= 1'b0;
         wt(0, 1'b0);
         chk(data_busy_out, 1'b0);
      end
      repeat (2) @(posedge core_clk);
      chk(n_ws, 3);
      chk(n_id, 1);
      chk(exp_q.size(), 0);
      // a foreign address must not see status or start motion
      hm.sel(3'h4);
      hm.issue(thic_pkg::thic_cmd_t'(6'h00));
      repeat (4) @(posedge core_clk);
      chk({online_out, ready_out, formatter_busy_out}, 3'h0);
      rd(thic_pkg::REG_STATUS, d, OK);
      chk({d[9:8], d[2]}, 3'h0);
      hm.sel(3'h5);
      bot_sensor <= 1'b1;
      hm.issue(thic_pkg::thic_cmd_t'(6'h10));
      repeat (6) @(posedge core_clk);
      chk(formatter_busy_out, 1'b0);
      bot_sensor <= 1'b0;
      hm.issue(thic_pkg::thic_cmd_t'(6'h10));
      wt(2, 1'b1);
      rd(thic_pkg::REG_STATUS, d, OK);
      chk(d[3:1], 3'h3);
      hard_err_evt <= 1'b1;
      bot_sensor <= 1'b1;
      @(posedge core_clk);
      hard_err_evt <= 1'b0;
      wt(2, 1'b0);
      chk(hard_error_out, 1'b1);
      wt(0, 1'b0);
      repeat (2) @(posedge core_clk);
      chk(ready_out, 1'b1);
      bot_sensor <= 1'b0;
      hm.issue(thic_pkg::thic_cmd_t'(6'h08));
      wt(3, 1'b0);
      bot_sensor <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk(n_ul, 1);
      wr(thic_pkg::REG_CTRL, 32'h15, OK);
      wt(3, 1'b1);
      wr(thic_pkg::REG_CTRL, 32'h25, OK);
      repeat (4) @(posedge core_clk);
      chk(online_out, 1'b0);
      close_out;
   end
endmodule // thic_ctl_test
